//--- logic/nfls_core.sv
// nfls_core: block protection, command decode and status output
`timescale 1ns/1ps
module nfls_core (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // parallel bus pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic address_valid_n,
    input wire logic wp_n,
    input wire logic [nfls_pkg::ADDR_W-1:0] addr,
    input wire logic [nfls_pkg::DQ_W-1:0] dq_in,
    output logic [nfls_pkg::DQ_W-1:0] dq_out,
    output logic dq_oe,
    // read configuration, same clock
    input wire logic sync_burst,
    // program/erase engine, same clock
    input wire nfls_pkg::nfls_engine_s engine,
    input wire logic [nfls_pkg::DQ_W-1:0] array_rdata,
    input wire logic [nfls_pkg::BLK_W-1:0] eng_block,
    output logic eng_block_locked,
    output logic [7:0] operation_status
);

    // ==================================================
    // pin synchronisation and edges
    nfls_pkg::nfls_pins_s pins_raw;
    nfls_pkg::nfls_pins_s pins_s;
    nfls_pkg::nfls_pins_s prev_q;

    assign pins_raw = '{ce_n, oe_n, we_n, address_valid_n, wp_n, addr, dq_in};

    nfls_sync #(
        .W($bits(nfls_pkg::nfls_pins_s)),
        .RESET_VAL(nfls_pkg::PINS_IDLE)
    ) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prev_q <= nfls_pkg::PINS_IDLE;
        end else if (clk_en) begin
            prev_q <= pins_s;
        end
    end

    logic wr_ev;
    logic fall_ce;
    logic fall_oe;
    logic fall_adv;
    logic rise_ce;
    logic rise_oe;
    logic [7:0] cmd;
    logic [nfls_pkg::BLK_W-1:0] wr_blk;

    // write taken at the rising edge of we_n while chip enable is low
    assign wr_ev = pins_s.we_n & ~prev_q.we_n & ~prev_q.ce_n;
    assign fall_ce = ~pins_s.ce_n & prev_q.ce_n;
    assign fall_oe = ~pins_s.oe_n & prev_q.oe_n;
    assign fall_adv = ~pins_s.address_valid_n & prev_q.address_valid_n;
    assign rise_ce = pins_s.ce_n & ~prev_q.ce_n;
    assign rise_oe = pins_s.oe_n & ~prev_q.oe_n;
    assign cmd = prev_q.dq[7:0];
    assign wr_blk = prev_q.addr[nfls_pkg::ADDR_W-1 -: nfls_pkg::BLK_W];

    function automatic logic is_protect_cmd(input logic [7:0] c);
        is_protect_cmd = (c == nfls_pkg::CMD_LOCK) || (c == nfls_pkg::CMD_UNLOCK)
            || (c == nfls_pkg::CMD_LOCK_DOWN);
    endfunction

    // ==================================================
    // control state
    nfls_pkg::nfls_mode_e mode_q;
    nfls_pkg::nfls_mode_e mode_d;
    logic setup_q;
    logic setup_d;
    logic [nfls_pkg::NUM_BLOCKS-1:0] lock_q;
    logic [nfls_pkg::NUM_BLOCKS-1:0] lock_d;
    logic [nfls_pkg::NUM_BLOCKS-1:0] lockdown_q;
    logic [nfls_pkg::NUM_BLOCKS-1:0] lockdown_d;
    logic [7:0] sticky_q;
    logic [7:0] sticky_d;
    logic [7:0] snap_q;
    logic [7:0] snap_d;
    logic armed_q;
    logic armed_d;
    logic clr_ev;
    logic seq_err;
    logic capture;
    logic [7:0] status_now;

    always_comb begin
        mode_d = mode_q;
        setup_d = setup_q;
        lock_d = lock_q;
        lockdown_d = lockdown_q;
        clr_ev = 1'b0;
        seq_err = 1'b0;
        if (wr_ev) begin
            if (setup_q) begin
                setup_d = 1'b0;
                mode_d = nfls_pkg::MODE_STATUS;
                if (!is_protect_cmd(cmd)) begin
                    seq_err = 1'b1;
                end else if (!engine.program_suspended_flag) begin
                    // changes apply at once, even to a block with suspended erase
                    unique case (cmd)
                        nfls_pkg::CMD_LOCK: begin
                            lock_d[wr_blk] = 1'b1;
                        end
                        nfls_pkg::CMD_UNLOCK: begin
                            if (!lockdown_q[wr_blk] || pins_s.wp_n) begin
                                lock_d[wr_blk] = 1'b0;
                                lockdown_d[wr_blk] = 1'b0;
                            end
                        end
                        default: begin
                            lock_d[wr_blk] = 1'b1;
                            lockdown_d[wr_blk] = 1'b1;
                        end
                    endcase
                end
            end else begin
                unique case (cmd)
                    nfls_pkg::CMD_READ_ARRAY: mode_d = nfls_pkg::MODE_ARRAY;
                    nfls_pkg::CMD_READ_STATUS: mode_d = nfls_pkg::MODE_STATUS;
                    nfls_pkg::CMD_READ_ID: mode_d = nfls_pkg::MODE_ID;
                    nfls_pkg::CMD_CLEAR_STATUS: clr_ev = 1'b1;
                    nfls_pkg::CMD_LOCK_SETUP: setup_d = 1'b1;
                    nfls_pkg::CMD_PROGRAM_A,
                    nfls_pkg::CMD_PROGRAM_B,
                    nfls_pkg::CMD_ERASE_SETUP,
                    nfls_pkg::CMD_CONFIRM,
                    nfls_pkg::CMD_SUSPEND: mode_d = nfls_pkg::MODE_STATUS;
                    default: mode_d = mode_q;
                endcase
            end
        end

        // sticky bits: events win over a clear in the same cycle
        sticky_d = clr_ev ? 8'h00 : sticky_q;
        sticky_d[nfls_pkg::SR_PROG_FAIL] = sticky_d[nfls_pkg::SR_PROG_FAIL]
            | engine.program_fail | seq_err;
        sticky_d[nfls_pkg::SR_ERASE_FAIL] = sticky_d[nfls_pkg::SR_ERASE_FAIL]
            | engine.erase_check_fail | seq_err;
        sticky_d[nfls_pkg::SR_SUPPLY_LOW] = sticky_d[nfls_pkg::SR_SUPPLY_LOW]
            | engine.supply_low_flag;
        sticky_d[nfls_pkg::SR_PROT_ABORT] = sticky_d[nfls_pkg::SR_PROT_ABORT]
            | engine.protected_abort_flag;

        // live bits follow the engine directly
        status_now = sticky_q & nfls_pkg::SR_STICKY_MASK;
        status_now[nfls_pkg::SR_READY] = ~engine.busy;
        status_now[nfls_pkg::SR_ERASE_SUSP] = engine.erase_suspended_flag;
        status_now[nfls_pkg::SR_PROG_SUSP] = engine.program_suspended_flag;
        status_now[nfls_pkg::SR_FAST_BUF] = engine.fast_buffer_busy;

        // async: first falling edge of a read; burst: every ce or adv falling edge
        if (sync_burst) begin
            capture = fall_ce | fall_adv;
        end else begin
            capture = (fall_ce | fall_oe) & armed_q;
        end
        armed_d = armed_q;
        if (capture) begin
            armed_d = 1'b0;
        end
        if (rise_ce | rise_oe) begin
            armed_d = 1'b1;
        end
        snap_d = capture ? status_now : snap_q;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_q <= nfls_pkg::MODE_ARRAY;
            setup_q <= 1'b0;
            lock_q <= '1;
            lockdown_q <= '0;
            sticky_q <= 8'h00;
            snap_q <= nfls_pkg::STATUS_RESET;
            armed_q <= 1'b1;
        end else if (clk_en) begin
            mode_q <= mode_d;
            setup_q <= setup_d;
            lock_q <= lock_d;
            lockdown_q <= lockdown_d;
            sticky_q <= sticky_d;
            snap_q <= snap_d;
            armed_q <= armed_d;
        end
    end

    // ==================================================
    // outputs
    logic [nfls_pkg::DQ_W-1:0] dq_out_q;
    logic [nfls_pkg::DQ_W-1:0] dq_out_d;
    logic dq_oe_q;
    logic dq_oe_d;
    logic locked_q;
    logic locked_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [nfls_pkg::BLK_W-1:0] rd_blk;

    assign rd_blk = pins_s.addr[nfls_pkg::ADDR_W-1 -: nfls_pkg::BLK_W];

    always_comb begin
        dq_oe_d = ~pins_s.ce_n & ~pins_s.oe_n;
        dq_out_d = nfls_pkg::DQ_ZERO;
        unique case (mode_q)
            nfls_pkg::MODE_ARRAY: dq_out_d = array_rdata;
            // same word held through page or burst
            nfls_pkg::MODE_STATUS: dq_out_d = {8'h00, snap_q};
            nfls_pkg::MODE_ID: begin
                if (pins_s.addr[3:0] == nfls_pkg::ID_LOCK_OFS) begin
                    dq_out_d[1:0] = {lockdown_q[rd_blk], lock_q[rd_blk]};
                end
            end
            default: dq_out_d = nfls_pkg::DQ_ZERO;
        endcase
        locked_d = lock_q[eng_block];
        status_d = status_now;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dq_out_q <= nfls_pkg::DQ_ZERO;
            dq_oe_q <= 1'b0;
            locked_q <= 1'b1;
            status_q <= nfls_pkg::STATUS_RESET;
        end else if (clk_en) begin
            dq_out_q <= dq_out_d;
            dq_oe_q <= dq_oe_d;
            locked_q <= locked_d;
            status_q <= status_d;
        end
    end

    assign dq_out = dq_out_q;
    assign dq_oe = dq_oe_q;
    assign eng_block_locked = locked_q;
    assign operation_status = status_q;

    // ==================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    lock_cmd_a: assert property (clk_en && wr_ev && setup_q && cmd == nfls_pkg::CMD_LOCK
        && !engine.program_suspended_flag |=> lock_q[$past(wr_blk)])
        else $error("lock command did not set lock bit");
    unlock_cmd_a: assert property (clk_en && wr_ev && setup_q && cmd == nfls_pkg::CMD_UNLOCK
        && !engine.program_suspended_flag && !lockdown_q[wr_blk] |=> !lock_q[$past(wr_blk)])
        else $error("unlock command did not clear lock bit");
    lockdown_cmd_a: assert property (clk_en && wr_ev && setup_q && cmd == nfls_pkg::CMD_LOCK_DOWN
        && !engine.program_suspended_flag |=> lockdown_q[$past(wr_blk)] && lock_q[$past(wr_blk)])
        else $error("lock-down command not applied");
    lockdown_hold_a: assert property (clk_en && wr_ev && setup_q && lockdown_q[wr_blk]
        && !pins_s.wp_n |=> lockdown_q[$past(wr_blk)])
        else $error("lock-down left while write-protect asserted");
    seq_error_a: assert property (clk_en && wr_ev && setup_q && !is_protect_cmd(cmd)
        |=> sticky_q[5:4] == 2'b11 ##1 (!clk_en || status_q[5:4] == 2'b11))
        else $error("sequence error not flagged");
    prog_susp_a: assert property (clk_en && wr_ev && setup_q && engine.program_suspended_flag
        |=> $stable(lock_q) && $stable(lockdown_q))
        else $error("protection changed during program suspend");
    status_mode_a: assert property (clk_en && wr_ev && !setup_q && cmd == nfls_pkg::CMD_READ_STATUS
        |=> mode_q == nfls_pkg::MODE_STATUS)
        else $error("read-status did not select status output");
    status_drive_a: assert property (clk_en && mode_q == nfls_pkg::MODE_STATUS
        |=> dq_out_q == {8'h00, $past(snap_q)})
        else $error("status word wrong on data bus");
    sticky_keep_a: assert property (clk_en && !clr_ev
        |=> (sticky_q & $past(sticky_q)) == $past(sticky_q))
        else $error("sticky status bit fell without clear");
    capture_a: assert property (clk_en && capture |=> snap_q == $past(status_now))
        else $error("status not captured at read start");

endmodule

//--- logic/nfls_pkg.sv
// nfls_pkg: constants and types for the flash protection and status block
package nfls_pkg;

    // ==================================================
    // geometry
    localparam int NUM_BLOCKS = 16;
    localparam int BLK_W = 4;
    localparam int ADDR_W = 8;
    localparam int DQ_W = 16;
    localparam logic [3:0] ID_LOCK_OFS = 4'h2;

    // ==================================================
    // command codes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK = 8'h01;
    localparam logic [7:0] CMD_UNLOCK = 8'hd0;
    localparam logic [7:0] CMD_LOCK_DOWN = 8'h2f;
    localparam logic [7:0] CMD_PROGRAM_A = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_B = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;

    // ==================================================
    // status layout
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam int SR_READY = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_ERASE_FAIL = 5;
    localparam int SR_PROG_FAIL = 4;
    localparam int SR_SUPPLY_LOW = 3;
    localparam int SR_PROG_SUSP = 2;
    localparam int SR_PROT_ABORT = 1;
    localparam int SR_FAST_BUF = 0;
    localparam logic [7:0] SR_STICKY_MASK = 8'h3a;
    localparam logic [DQ_W-1:0] DQ_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        MODE_ARRAY,
        MODE_STATUS,
        MODE_ID
    } nfls_mode_e;

    // parallel bus pins, all asynchronous to ref_clk
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic address_valid_n;
        logic wp_n;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dq;
    } nfls_pins_s;

    localparam nfls_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 16'h0000};

    // live state and one-cycle events from the program/erase engine
    typedef struct packed {
        logic busy;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic fast_buffer_busy;
        logic program_fail;
        logic erase_check_fail;
        logic supply_low_flag;
        logic protected_abort_flag;
    } nfls_engine_s;

endpackage

//--- logic/nfls_sync.sv
// nfls_sync: two-stage synchroniser for a group of pins
`timescale 1ns/1ps
module nfls_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // clock and control
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

//--- bench/nfls_host.sv
// nfls_host: host controller model driving the parallel bus pins
`timescale 1ns/1ps
module nfls_host (
    // clock
    input wire logic ref_clk,
    // data from device
    input wire logic [nfls_pkg::DQ_W-1:0] dq_out,
    input wire logic dq_oe,
    // pins to device
    output nfls_pkg::nfls_pins_s pins
);
    initial begin
        pins = nfls_pkg::PINS_IDLE;
    end

    // ==================================================
    // timing: inputs change 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // ==================================================
    // control pins, held long enough for the synchronisers
    task automatic set_ctl(input logic ce, input logic oe, input logic av, input logic wp);
        pins.ce_n = ce;
        pins.oe_n = oe;
        pins.address_valid_n = av;
        pins.wp_n = wp;
        step(4);
    endtask

    // ==================================================
    // one bus write; each we_n level stands 4 cycles
    task automatic write_cmd(input logic [7:0] cmd, input logic [3:0] blk);
        pins.ce_n = 1'b0;
        pins.addr = {blk, 4'h0};
        pins.dq = {8'h00, cmd};
        pins.we_n = 1'b0;
        step(4);
        pins.we_n = 1'b1;
        step(4);
        pins.ce_n = 1'b1;
        // released bus never keeps the last value
        pins.dq = ~pins.dq;
        step(4);
    endtask

    // ==================================================
    // protection sequence: setup then code
    task automatic protect(input logic [7:0] code, input logic [3:0] blk);
        write_cmd(nfls_pkg::CMD_LOCK_SETUP, blk);
        write_cmd(code, blk);
    endtask

    // clear status and wait out the recovery delay
    task automatic clear_status();
        write_cmd(nfls_pkg::CMD_CLEAR_STATUS, 4'h0);
        step(1500);
    endtask

    // ==================================================
    // asynchronous single read, bounded wait for dq_oe
    task automatic read_word(input logic [7:0] a, output logic [15:0] d, output bit ok);
        int i;
        ok = 1'b0;
        pins.addr = a;
        pins.ce_n = 1'b0;
        pins.oe_n = 1'b0;
        for (i = 0; i < 20 && !ok; i++) begin
            step(1);
            ok = (dq_oe === 1'b1);
        end
        step(2);
        d = dq_out;
        pins.oe_n = 1'b1;
        pins.ce_n = 1'b1;
        step(4);
    endtask
endmodule

//--- bench/testbench.sv
// testbench: scenarios for the flash protection and status block
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic sync_burst = 1'b0;
    nfls_pkg::nfls_engine_s engine = '0;
    logic [nfls_pkg::DQ_W-1:0] array_rdata = 16'h1234;
    logic [nfls_pkg::BLK_W-1:0] eng_block = 4'h3;
    nfls_pkg::nfls_pins_s pins;
    logic [nfls_pkg::DQ_W-1:0] dq_out;
    logic dq_oe;
    logic eng_block_locked;
    logic [7:0] operation_status;
    int mismatches = 0;
    int comparisons = 0;
    logic [15:0] rd;
    bit ok;

    always #5 ref_clk = ~ref_clk;

    nfls_core nfls_core_inst (
        .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
        .ce_n(pins.ce_n), .oe_n(pins.oe_n), .we_n(pins.we_n),
        .address_valid_n(pins.address_valid_n), .wp_n(pins.wp_n),
        .addr(pins.addr), .dq_in(pins.dq), .dq_out(dq_out), .dq_oe(dq_oe),
        .sync_burst(sync_burst), .engine(engine), .array_rdata(array_rdata),
        .eng_block(eng_block), .eng_block_locked(eng_block_locked),
        .operation_status(operation_status)
    );

    nfls_host nfls_host_inst (.ref_clk(ref_clk), .dq_out(dq_out), .dq_oe(dq_oe), .pins(pins));

    // ==================================================
    // helpers
    task automatic tk(input int n);
        nfls_host_inst.step(n);
    endtask

    task automatic wr(input logic [7:0] c, input logic [3:0] b);
        nfls_host_inst.write_cmd(c, b);
    endtask

    task automatic pr(input logic [7:0] c, input logic [3:0] b);
        nfls_host_inst.protect(c, b);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic sr(input string name, input logic [7:0] exp);
        check(name, {8'h00, exp}, {8'h00, operation_status});
    endtask

    task automatic lk(input string name, input logic exp);
        tk(2);
        check(name, {15'h0000, exp}, {15'h0000, eng_block_locked});
    endtask

    task automatic rc(input string name, input logic [7:0] a, input logic [15:0] exp);
        nfls_host_inst.read_word(a, rd, ok);
        if (!ok) begin
            mismatches++;
            $display("mismatch %s_oe expected 1 seen 0", name);
            final_report();
        end
        check(name, exp, rd);
    endtask

    // ==================================================
    // scenarios
    task automatic t_reset();
        sr("status_rst", 8'h80);
        lk("locked_rst", 1'b1);
        wr(nfls_pkg::CMD_READ_ID, 4'h3);
        rc("id_rst", 8'h32, 16'h0001);
        $display("test reset done");
    endtask

    task automatic t_lock();
        pr(nfls_pkg::CMD_UNLOCK, 4'h3);
        rc("auto_status", 8'h30, 16'h0080);
        lk("unlocked", 1'b0);
        pr(nfls_pkg::CMD_LOCK, 4'h3);
        lk("locked", 1'b1);
        pr(nfls_pkg::CMD_LOCK_DOWN, 4'h3);
        wr(nfls_pkg::CMD_READ_ID, 4'h3);
        rc("id_down", 8'h32, 16'h0003);
        nfls_host_inst.set_ctl(1'b1, 1'b1, 1'b1, 1'b0);
        pr(nfls_pkg::CMD_UNLOCK, 4'h3);
        lk("down_wp_low", 1'b1);
        nfls_host_inst.set_ctl(1'b1, 1'b1, 1'b1, 1'b1);
        pr(nfls_pkg::CMD_UNLOCK, 4'h3);
        lk("down_wp_high", 1'b0);
        $display("test lock done");
    endtask

    task automatic t_seq_err();
        wr(nfls_pkg::CMD_LOCK_SETUP, 4'h3);
        wr(8'h77, 4'h3);
        wr(nfls_pkg::CMD_READ_STATUS, 4'h3);
        rc("seq_err", 8'h30, 16'h00b0);
        engine.busy = 1'b1;
        tk(4);
        engine.busy = 1'b0;
        tk(4);
        sr("sticky_busy", 8'hb0);
        nfls_host_inst.clear_status();
        sr("cleared", 8'h80);
        $display("test sequence error done");
    endtask

    task automatic t_erase_susp();
        eng_block = 4'h5;
        wr(nfls_pkg::CMD_ERASE_SETUP, 4'h5);
        wr(nfls_pkg::CMD_CONFIRM, 4'h5);
        engine.busy = 1'b1;
        tk(3);
        sr("busy", 8'h00);
        wr(nfls_pkg::CMD_SUSPEND, 4'h5);
        engine.busy = 1'b0;
        engine.erase_suspended_flag = 1'b1;
        wr(nfls_pkg::CMD_READ_STATUS, 4'h5);
        rc("susp_poll", 8'h50, 16'h00c0);
        pr(nfls_pkg::CMD_UNLOCK, 4'h5);
        lk("susp_unlock", 1'b0);
        pr(nfls_pkg::CMD_LOCK, 4'h5);
        lk("susp_lock", 1'b1);
        wr(nfls_pkg::CMD_LOCK_SETUP, 4'h5);
        wr(8'h77, 4'h5);
        sr("susp_err", 8'hf0);
        wr(nfls_pkg::CMD_CONFIRM, 4'h5);
        engine.erase_suspended_flag = 1'b0;
        engine.busy = 1'b1;
        tk(3);
        sr("resumed_err", 8'h30);
        engine.busy = 1'b0;
        nfls_host_inst.clear_status();
        sr("resume_clr", 8'h80);
        // second suspend: error cleared before resuming
        engine.erase_suspended_flag = 1'b1;
        wr(nfls_pkg::CMD_LOCK_SETUP, 4'h5);
        wr(8'h77, 4'h5);
        nfls_host_inst.clear_status();
        wr(nfls_pkg::CMD_CONFIRM, 4'h5);
        engine.erase_suspended_flag = 1'b0;
        engine.busy = 1'b1;
        tk(3);
        sr("clr_resumed", 8'h00);
        engine.busy = 1'b0;
        $display("test erase suspend done");
    endtask

    task automatic t_prog_susp();
        eng_block = 4'h6;
        wr(nfls_pkg::CMD_PROGRAM_A, 4'h6);
        engine.program_suspended_flag = 1'b1;
        pr(nfls_pkg::CMD_UNLOCK, 4'h6);
        lk("psusp_refused", 1'b1);
        sr("psusp_flag", 8'h84);
        engine.program_suspended_flag = 1'b0;
        tk(3);
        $display("test program suspend done");
    endtask

    task automatic t_events();
        logic [7:0] ev [4] = '{8'h08, 8'h04, 8'h02, 8'h01};
        logic [7:0] exp [4] = '{8'h90, 8'ha0, 8'h88, 8'h82};
        int i;
        for (i = 0; i < 4; i++) begin
            engine = ev[i];
            tk(1);
            engine = '0;
            tk(4);
            sr("event_sticky", exp[i]);
            nfls_host_inst.clear_status();
            sr("event_clr", 8'h80);
        end
        $display("test events done");
    endtask

    task automatic t_modes();
        wr(nfls_pkg::CMD_READ_ARRAY, 4'h9);
        rc("array", 8'h90, 16'h1234);
        wr(nfls_pkg::CMD_PROGRAM_B, 4'h9);
        rc("prog_status", 8'h93, 16'h0080);
        wr(nfls_pkg::CMD_READ_STATUS, 4'h9);
        engine.busy = 1'b1;
        rc("async_busy", 8'h91, 16'h0000);
        engine.busy = 1'b0;
        rc("async_ready", 8'h92, 16'h0080);
        // ce falls first while busy; the later oe fall must not recapture
        engine.busy = 1'b1;
        nfls_host_inst.set_ctl(1'b0, 1'b1, 1'b1, 1'b1);
        engine.busy = 1'b0;
        nfls_host_inst.set_ctl(1'b0, 1'b0, 1'b1, 1'b1);
        tk(2);
        check("async_first_edge", 16'h0000, dq_out);
        nfls_host_inst.set_ctl(1'b1, 1'b1, 1'b1, 1'b1);
        sync_burst = 1'b1;
        engine.busy = 1'b1;
        nfls_host_inst.set_ctl(1'b0, 1'b0, 1'b1, 1'b1);
        tk(2);
        check("burst_first", 16'h0000, dq_out);
        engine.busy = 1'b0;
        tk(6);
        check("burst_repeat", 16'h0000, dq_out);
        nfls_host_inst.set_ctl(1'b0, 1'b0, 1'b0, 1'b1);
        tk(2);
        check("burst_refresh", 16'h0080, dq_out);
        nfls_host_inst.set_ctl(1'b1, 1'b1, 1'b1, 1'b1);
        sync_burst = 1'b0;
        $display("test read modes done");
    endtask

    task automatic t_freeze();
        clk_en = 1'b0;
        engine.busy = 1'b1;
        tk(3);
        sr("frozen", 8'h80);
        clk_en = 1'b1;
        tk(2);
        sr("thawed", 8'h00);
        engine.busy = 1'b0;
        tk(2);
        $display("test clock enable done");
    endtask

    task automatic t_reset_mid();
        eng_block = 4'h3;
        pr(nfls_pkg::CMD_LOCK_DOWN, 4'h3);
        engine.program_fail = 1'b1;
        tk(1);
        engine.program_fail = 1'b0;
        srst = 1'b1;
        tk(3);
        srst = 1'b0;
        tk(2);
        sr("mid_rst_status", 8'h80);
        lk("mid_rst_lock", 1'b1);
        wr(nfls_pkg::CMD_READ_ID, 4'h3);
        rc("mid_rst_id", 8'h32, 16'h0001);
        $display("test second reset done");
    endtask

    initial begin
        tk(3);
        srst = 1'b0;
        tk(2);
        t_reset();
        t_lock();
        t_seq_err();
        t_erase_susp();
        t_prog_susp();
        t_events();
        t_modes();
        t_freeze();
        t_reset_mid();
        final_report();
    end
endmodule
